// file: rtl/bpw_cfg.svh
// offsets, field positions, reset values and timing counts of the prefetch window slice
`ifndef BPW_CFG_SVH
`define BPW_CFG_SVH

// ----------------------------------------------------------------
// configuration byte offsets
// ----------------------------------------------------------------
`define BPW_OFF_PF_BOTTOM 8'h24
`define BPW_OFF_PF_TOP 8'h26
`define BPW_OFF_PF_BOTTOM_HIGH 8'h28
`define BPW_OFF_PF_TOP_HIGH 8'h2C
`define BPW_OFF_IO_BOTTOM_HIGH 8'h30
`define BPW_OFF_IO_TOP_HIGH 8'h32
`define BPW_OFF_INT_LINE 8'h3C
`define BPW_OFF_BRIDGE_CTL 8'h3E

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BPW_WIN_FIELD_LSB 4
`define BPW_WIN_FIELD_MSB 15
`define BPW_HIGH_FIELD_MSB 11
`define BPW_CTL_FREQ 15
`define BPW_CTL_TMO_GLOBAL_SYSTEM_ERROR_ENABLE 11
`define BPW_CTL_TMO_STS 10
`define BPW_CTL_TMO_SEL 9

// ----------------------------------------------------------------
// reset and hardwired values
// ----------------------------------------------------------------
`define BPW_RST_WIN_FIELD 12'h000
`define BPW_RST_HIGH_FIELD 12'h000
`define BPW_RST_CTL_BIT 1'b0
`define BPW_ADDR_CAP_CODE 4'h0
`define BPW_IO_HIGH_VALUE 16'h0000
`define BPW_INT_LINE_VALUE 8'h00
`define BPW_BOTTOM_LOW_FILL 20'h00000
`define BPW_TOP_LOW_FILL 20'hFFFFF

// ----------------------------------------------------------------
// master timeout lengths in bus clocks
// ----------------------------------------------------------------
`define BPW_TMO_LONG 32768
`define BPW_TMO_SHORT 1024

`endif

// file: rtl/bpw_pkg.sv
// types shared by the prefetch window slice
`default_nettype none

package bpw_pkg;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} bpw_cfg_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} bpw_cfg_rsp_t;

	typedef struct packed {
		logic [11:0] bottom;
		logic [11:0] top;
		logic [11:0] bottom_high;
		logic [11:0] top_high;
	} bpw_window_t;

	typedef enum logic [0:0] {
		BPW_TMR_IDLE,
		BPW_TMR_COUNT
	} bpw_tmr_state_t;

	typedef struct packed {
		logic fwd_valid;
		logic fwd_hit;
	} bpw_dec_state_t;

endpackage

`default_nettype wire

// file: rtl/bpw_window_decode.sv
// prefetchable window address decoder with registered result
`timescale 1ns/1ps
`default_nettype none
`include "bpw_cfg.svh"

module bpw_window_decode (
	input wire logic clk,
	input wire logic nrst,
	input wire bpw_pkg::bpw_window_t win,
	input wire logic mem_req_valid,
	input wire logic [63:0] mem_req_addr,
	output logic fwd_valid,
	output logic fwd_hit
);

	bpw_pkg::bpw_dec_state_t st;
	bpw_pkg::bpw_dec_state_t next_st;
	logic [43:0] lo_edge;
	logic [43:0] hi_edge;
	logic in_reach;

	// ----------------------------------------------------------------
	// window edges
	// ----------------------------------------------------------------
	// bottom low bits are zero, top low bits are all ones
	assign lo_edge = {win.bottom_high, win.bottom, `BPW_BOTTOM_LOW_FILL}; // R16 R7
	assign hi_edge = {win.top_high, win.top, `BPW_TOP_LOW_FILL}; // R1 R2 R7
	// addresses with any of bits 63:44 set never hit
	assign in_reach = (mem_req_addr[63:44] == 20'h00000);

	always_comb begin
		next_st = st;
		next_st.fwd_valid = mem_req_valid;
		next_st.fwd_hit = mem_req_valid && in_reach
			&& (mem_req_addr[43:0] >= lo_edge)
			&& (mem_req_addr[43:0] <= hi_edge); // R3
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign fwd_valid = st.fwd_valid;
	assign fwd_hit = st.fwd_hit;

endmodule // bpw_window_decode

`default_nettype wire

// file: rtl/bpw_regs.sv
// prefetch window, hardwired words and bridge control upper bits
//
// Summary of operation
// R1: top field bits 15:4 compare with incoming address bits 31:20.
// R2: top edge low 20 address bits are taken as all ones.
// R3: memory reads and writes inside the window are forwarded, 1 MB granular.
// R4: top register bits 3:0 read-only addressing code, writes ignored.
// R5: bottom upper register writable in 11:0, 31:12 reserved, 44-bit reach.
// R6: top upper register writable in 11:0, 31:12 reserved, 44-bit reach.
// R7: upper register gives upper half of the window edge address.
// R8: I/O bottom upper sixteen bits read-only zero.
// R9: I/O top upper sixteen bits read-only zero.
// R10: interrupt line register read-only zero, bridge raises no interrupts.
// R11: control bit 15 reports bus speed, 1 for 66 MHz.
// R12: control bit 11 gates the error special cycle on timeout.
// R13: control bit 10 set when timeout expires and completion is dropped.
// R14: special cycle sent when status, its enable and global enable set.
// R15: writing one clears the timeout status, zero leaves it.
// R16: bottom field gives address bits 31:20, low 20 bits zero.
// R17: timer starts at queue head, expiry drops completion, bit 9 selects length.
// R18: global error enable comes from outside this slice.
// R19: reserved bits ignore writes and read zero.
// R20: writable fields reset to zero.
`timescale 1ns/1ps
`default_nettype none
`include "bpw_cfg.svh"

module bpw_regs #(
	parameter int unsigned LONG_TIMEOUT = `BPW_TMO_LONG,
	parameter int unsigned SHORT_TIMEOUT = `BPW_TMO_SHORT
) (
	input wire logic clk,
	input wire logic nrst,
	input wire bpw_pkg::bpw_cfg_req_t cfg_req,
	output var bpw_pkg::bpw_cfg_rsp_t cfg_rsp,
	input wire logic mem_req_valid,
	input wire logic [63:0] mem_req_addr,
	output logic fwd_valid,
	output logic fwd_hit,
	input wire logic bus_is_66mhz,
	input wire logic global_system_error_enable,
	input wire logic pci_tick,
	input wire logic completion_at_head,
	input wire logic completion_repeated,
	output logic completion_discard,
	output logic serr_cycle_req
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		bpw_pkg::bpw_window_t win;
		logic tmo_global_system_error_enable;
		logic tmo_sts;
		logic tmo_sel;
		logic freq66;
		bpw_pkg::bpw_tmr_state_t tmr;
		logic [15:0] count;
		logic discard;
		logic serr_sent;
		logic serr_pulse;
		logic ack;
		logic [31:0] rdata;
	} bpw_state_t;

	bpw_state_t st;
	bpw_state_t next_st;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// byte-lane merge of a write into an old dword image
	function automatic logic [31:0] bpw_merge(
		input logic [31:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0] byte_en
	);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (byte_en[i]) begin
				res[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// dword match of a byte offset
	function automatic logic bpw_hit(
		input logic [7:0] addr,
		input logic [7:0] offset
	);
		return addr[7:2] == offset[7:2];
	endfunction

	// 16-bit window register image from its field
	function automatic logic [15:0] bpw_win_word(input logic [11:0] field);
		return {field, `BPW_ADDR_CAP_CODE};
	endfunction

	// ----------------------------------------------------------------
	// register images
	// ----------------------------------------------------------------
	logic [15:0] ctl_word;
	logic [31:0] dw_pf_window;
	logic [31:0] dw_pf_bottom_high;
	logic [31:0] dw_pf_top_high;
	logic [31:0] dw_io_high;
	logic [31:0] dw_int_ctl;
	logic [31:0] rd_mux;

	always_comb begin
		ctl_word = 16'h0000; // R19
		ctl_word[`BPW_CTL_FREQ] = st.freq66; // R11
		ctl_word[`BPW_CTL_TMO_GLOBAL_SYSTEM_ERROR_ENABLE] = st.tmo_global_system_error_enable;
		ctl_word[`BPW_CTL_TMO_STS] = st.tmo_sts;
		ctl_word[`BPW_CTL_TMO_SEL] = st.tmo_sel;
	end

	// low code nibble is fixed in both window words
	assign dw_pf_window = {bpw_win_word(st.win.top), bpw_win_word(st.win.bottom)}; // R4
	assign dw_pf_bottom_high = {20'h00000, st.win.bottom_high}; // R5 R19
	assign dw_pf_top_high = {20'h00000, st.win.top_high}; // R6 R19
	assign dw_io_high = {`BPW_IO_HIGH_VALUE, `BPW_IO_HIGH_VALUE}; // R8 R9
	// interrupt pin byte lies outside the slice and reads zero
	assign dw_int_ctl = {ctl_word, 8'h00, `BPW_INT_LINE_VALUE}; // R10

	always_comb begin
		rd_mux = 32'h00000000;
		if (bpw_hit(cfg_req.addr, `BPW_OFF_PF_BOTTOM)) begin
			rd_mux = dw_pf_window;
		end else if (bpw_hit(cfg_req.addr, `BPW_OFF_PF_BOTTOM_HIGH)) begin
			rd_mux = dw_pf_bottom_high;
		end else if (bpw_hit(cfg_req.addr, `BPW_OFF_PF_TOP_HIGH)) begin
			rd_mux = dw_pf_top_high;
		end else if (bpw_hit(cfg_req.addr, `BPW_OFF_IO_BOTTOM_HIGH)) begin
			rd_mux = dw_io_high;
		end else if (bpw_hit(cfg_req.addr, `BPW_OFF_INT_LINE)) begin
			rd_mux = dw_int_ctl;
		end
	end

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	logic wr;
	logic wr_window;
	logic wr_bottom_high;
	logic wr_top_high;
	logic wr_ctl;
	logic [31:0] mg_window;
	logic [31:0] mg_bottom_high;
	logic [31:0] mg_top_high;
	logic [31:0] mg_ctl;
	logic [15:0] ctl_wr;
	logic sts_clear;

	assign wr = cfg_req.valid && cfg_req.write;
	assign wr_window = wr && bpw_hit(cfg_req.addr, `BPW_OFF_PF_TOP);
	assign wr_bottom_high = wr && bpw_hit(cfg_req.addr, `BPW_OFF_PF_BOTTOM_HIGH);
	assign wr_top_high = wr && bpw_hit(cfg_req.addr, `BPW_OFF_PF_TOP_HIGH);
	assign wr_ctl = wr && bpw_hit(cfg_req.addr, `BPW_OFF_BRIDGE_CTL);

	assign mg_window = bpw_merge(dw_pf_window, cfg_req.wdata, cfg_req.byte_en);
	assign mg_bottom_high = bpw_merge(dw_pf_bottom_high, cfg_req.wdata, cfg_req.byte_en);
	assign mg_top_high = bpw_merge(dw_pf_top_high, cfg_req.wdata, cfg_req.byte_en);
	assign mg_ctl = bpw_merge(dw_int_ctl, cfg_req.wdata, cfg_req.byte_en);
	assign ctl_wr = mg_ctl[31:16];

	// only a one written through the enabled lane clears the status
	assign sts_clear = wr_ctl && cfg_req.byte_en[3]
		&& cfg_req.wdata[16 + `BPW_CTL_TMO_STS]; // R15

	// ----------------------------------------------------------------
	// timeout length
	// ----------------------------------------------------------------
	logic [15:0] tmo_load;

	always_comb begin
		if (st.tmo_sel) begin
			tmo_load = 16'(SHORT_TIMEOUT - 1);
		end else begin
			tmo_load = 16'(LONG_TIMEOUT - 1);
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic expire;
	logic serr_cond;

	always_comb begin
		next_st = st;
		expire = 1'b0;
		next_st.discard = 1'b0;

		// configuration answer, one cycle after the request
		next_st.ack = cfg_req.valid;
		if (cfg_req.valid && !cfg_req.write) begin
			next_st.rdata = rd_mux;
		end

		// window fields, reserved and code bits are dropped
		if (wr_window) begin
			next_st.win.bottom = mg_window[`BPW_WIN_FIELD_MSB:`BPW_WIN_FIELD_LSB]; // R16
			next_st.win.top = mg_window[16 + `BPW_WIN_FIELD_MSB:16 + `BPW_WIN_FIELD_LSB]; // R1 R4
		end
		if (wr_bottom_high) begin
			next_st.win.bottom_high = mg_bottom_high[`BPW_HIGH_FIELD_MSB:0]; // R5
		end
		if (wr_top_high) begin
			next_st.win.top_high = mg_top_high[`BPW_HIGH_FIELD_MSB:0]; // R6
		end

		// control bits, bit 15 and reserved bits take no write
		if (wr_ctl) begin
			next_st.tmo_global_system_error_enable = ctl_wr[`BPW_CTL_TMO_GLOBAL_SYSTEM_ERROR_ENABLE]; // R12
			next_st.tmo_sel = ctl_wr[`BPW_CTL_TMO_SEL];
		end
		next_st.freq66 = bus_is_66mhz; // R11

		// master timeout timer on bus clock enables
		case (st.tmr)
			bpw_pkg::BPW_TMR_IDLE: begin
				if (completion_at_head) begin
					next_st.tmr = bpw_pkg::BPW_TMR_COUNT; // R17
					next_st.count = tmo_load;
				end
			end
			bpw_pkg::BPW_TMR_COUNT: begin
				if (!completion_at_head || completion_repeated) begin
					next_st.tmr = bpw_pkg::BPW_TMR_IDLE;
				end else if (pci_tick) begin
					if (st.count == 16'h0000) begin
						expire = 1'b1; // R17
						next_st.tmr = bpw_pkg::BPW_TMR_IDLE;
					end else begin
						next_st.count = st.count - 16'h0001;
					end
				end
			end
			default: begin
				next_st.tmr = bpw_pkg::BPW_TMR_IDLE;
			end
		endcase
		next_st.discard = expire; // R17

		// status: a new expiry beats a clear in the same cycle
		next_st.tmo_sts = (st.tmo_sts && !sts_clear) || expire; // R13 R15

		// one special cycle per rise of the combined condition
		serr_cond = st.tmo_sts && st.tmo_global_system_error_enable && global_system_error_enable; // R14 R18
		next_st.serr_pulse = serr_cond && !st.serr_sent; // R12 R14
		next_st.serr_sent = serr_cond;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0; // R20
			st.win.bottom <= `BPW_RST_WIN_FIELD;
			st.win.top <= `BPW_RST_WIN_FIELD;
			st.win.bottom_high <= `BPW_RST_HIGH_FIELD;
			st.win.top_high <= `BPW_RST_HIGH_FIELD;
			st.tmo_global_system_error_enable <= `BPW_RST_CTL_BIT;
			st.tmo_sts <= `BPW_RST_CTL_BIT;
			st.tmo_sel <= `BPW_RST_CTL_BIT;
			st.tmr <= bpw_pkg::BPW_TMR_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// window decoder
	// ----------------------------------------------------------------
	bpw_window_decode u_decode (
		.clk(clk),
		.nrst(nrst),
		.win(st.win),
		.mem_req_valid(mem_req_valid),
		.mem_req_addr(mem_req_addr),
		.fwd_valid(fwd_valid),
		.fwd_hit(fwd_hit)
	); // R3

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign cfg_rsp.ack = st.ack;
	assign cfg_rsp.rdata = st.rdata;
	assign completion_discard = st.discard;
	assign serr_cycle_req = st.serr_pulse;

endmodule // bpw_regs

`default_nettype wire

// file: sim/bpw_regs_checker.sv
// port assertions for the prefetch window register slice
`timescale 1ns/1ps
`default_nettype none

module bpw_regs_checker #(
	parameter int unsigned LONG_TIMEOUT = 32768,
	parameter int unsigned SHORT_TIMEOUT = 1024
) (
	input wire logic clk,
	input wire logic nrst,
	input wire bpw_pkg::bpw_cfg_req_t cfg_req,
	input wire bpw_pkg::bpw_cfg_rsp_t cfg_rsp,
	input wire logic mem_req_valid,
	input wire logic [63:0] mem_req_addr,
	input wire logic fwd_valid,
	input wire logic fwd_hit,
	input wire logic bus_is_66mhz,
	input wire logic global_system_error_enable,
	input wire logic pci_tick,
	input wire logic completion_at_head,
	input wire logic completion_repeated,
	input wire logic completion_discard,
	input wire logic serr_cycle_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic rd_req;
	logic [5:0] dw;
	assign rd_req = cfg_req.valid && !cfg_req.write;
	assign dw = cfg_req.addr[7:2];

	// ----------------------------------------------------------------
	// config access and decode
	// ----------------------------------------------------------------
	a_ack_follows: assert property (cfg_req.valid |=> cfg_rsp.ack)
		else $error("no ack after request");
	a_ack_cause: assert property (cfg_rsp.ack |-> $past(cfg_req.valid))
		else $error("ack without request");
	a_rdata_hold: assert property (!rd_req |=> $stable(cfg_rsp.rdata))
		else $error("read data moved without a read");
	a_fwd_lag: assert property (1'b1 |=> fwd_valid == $past(mem_req_valid))
		else $error("decode result not one cycle late");
	a_hit_valid: assert property (fwd_hit |-> fwd_valid)
		else $error("hit without valid");
	a_reach_limit: assert property (mem_req_valid && mem_req_addr[63:44] != '0 |=> !fwd_hit)
		else $error("hit above 44-bit reach");
	a_nibble_ro: assert property (rd_req && dw == 6'h09 |=>
		cfg_rsp.rdata[19:16] == 4'h0 && cfg_rsp.rdata[3:0] == 4'h0)
		else $error("window low nibble not zero");
	a_high_rsvd: assert property (rd_req && (dw == 6'h0A || dw == 6'h0B) |=>
		cfg_rsp.rdata[31:12] == '0)
		else $error("upper address reserved bits set");
	a_io_zero: assert property (rd_req && dw == 6'h0C |=> cfg_rsp.rdata == 32'h0)
		else $error("io upper words not zero");
	a_int_zero: assert property (rd_req && dw == 6'h0F |=>
		cfg_rsp.rdata[15:0] == 16'h0 && cfg_rsp.rdata[30:28] == 3'h0)
		else $error("interrupt line or reserved control bits set");
	a_freq_bit: assert property (rd_req && dw == 6'h0F && $past(nrst) |=>
		cfg_rsp.rdata[31] == $past(bus_is_66mhz, 2))
		else $error("bus speed bit wrong");

	// ----------------------------------------------------------------
	// timeout and error cycle
	// ----------------------------------------------------------------
	a_discard_cause: assert property (completion_discard |->
		$past(pci_tick) && $past(completion_at_head) && !$past(completion_repeated))
		else $error("discard without expiring tick");
	a_discard_once: assert property (completion_discard |=> !completion_discard)
		else $error("discard longer than one cycle");
	a_serr_gate: assert property (serr_cycle_req |->
		$past(global_system_error_enable) && !$past(serr_cycle_req))
		else $error("error cycle without global enable");

	c_hit: cover property (fwd_hit);
	c_discard: cover property (completion_discard);
	c_serr: cover property (serr_cycle_req);
endmodule // bpw_regs_checker

`default_nettype wire

// file: sim/bpw_host_model.sv
// host-side config master for the register slice
`timescale 1ns/1ps
`default_nettype none

module bpw_host_model (
	input wire logic clk,
	output var bpw_pkg::bpw_cfg_req_t req,
	input wire bpw_pkg::bpw_cfg_rsp_t rsp
);
	initial req = '0;

	// one request per call, answer taken one cycle later
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic ack, output logic [31:0] q);
		@(posedge clk);
		#1;
		req = '{valid: 1'b1, write: w, addr: a, byte_en: be, wdata: d};
		@(posedge clk);
		#1;
		ack = rsp.ack;
		q = rsp.rdata;
		req = '{valid: 1'b0, write: ~w, addr: ~a, byte_en: ~be, wdata: ~d};
	endtask
endmodule // bpw_host_model

`default_nettype wire

// file: sim/bpw_regs_test.sv
// self-checking bench for the prefetch window register slice
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module bpw_regs_test;
	localparam int unsigned LONG_T = 8;
	localparam int unsigned SHORT_T = 4;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	bpw_pkg::bpw_cfg_req_t cfg_req;
	bpw_pkg::bpw_cfg_rsp_t cfg_rsp;
	logic mem_req_valid = 1'b0;
	logic [63:0] mem_req_addr = 64'h0;
	logic bus_is_66mhz = 1'b0;
	logic glob_en = 1'b0;
	logic pci_tick = 1'b0;
	logic at_head = 1'b0;
	logic rep = 1'b0;
	logic fwd_valid, fwd_hit, completion_discard, serr_cycle_req;
	int n_errors = 0;
	int checked = 0;
	int cyc = 0;
	int n;
	logic [63:0] dec_addr [6] = '{64'h0000_0001_1000_0000, 64'h0000_0001_0FFF_FFFF,
		64'h0000_0001_1FFF_FFFF, 64'h0000_0001_2000_0000, 64'h0000_1001_1000_0000,
		64'h0000_0000_1000_0000};
	logic dec_hit [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
	logic [7:0] ctl_b [3] = '{8'h0A, 8'h00, 8'h08};
	logic glob_v [3] = '{1'b1, 1'b1, 1'b0};
	logic serr_v [3] = '{1'b1, 1'b0, 1'b0};
	int exp_n [3] = '{SHORT_T + 1, LONG_T + 1, LONG_T + 1};

	bpw_regs #(.LONG_TIMEOUT(LONG_T), .SHORT_TIMEOUT(SHORT_T)) u_bpw_regs (
		.clk(clk), .nrst(nrst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
		.mem_req_valid(mem_req_valid), .mem_req_addr(mem_req_addr),
		.fwd_valid(fwd_valid), .fwd_hit(fwd_hit), .bus_is_66mhz(bus_is_66mhz),
		.global_system_error_enable(glob_en), .pci_tick(pci_tick),
		.completion_at_head(at_head), .completion_repeated(rep),
		.completion_discard(completion_discard), .serr_cycle_req(serr_cycle_req));
	bpw_host_model u_bpw_host_model (.clk(clk), .req(cfg_req), .rsp(cfg_rsp));

	initial begin
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		logic ack;
		logic [31:0] q;
		u_bpw_host_model.xfer(1'b1, a, be, d, ack, q);
		`CHK(ack, 1'b1)
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic ack;
		logic [31:0] q;
		u_bpw_host_model.xfer(1'b0, a, 4'hF, 32'h0, ack, q);
		`CHK(ack, 1'b1)
		`CHK(q, exp)
	endtask

	initial begin
		repeat (2) @(posedge clk);
		#1;
		nrst = 1'b1;
		// ----------------------------------------------------------------
		// reset values and read-only words
		// ----------------------------------------------------------------
		rc(8'h24, 32'h0);
		rc(8'h28, 32'h0);
		rc(8'h2C, 32'h0);
		rc(8'h30, 32'h0);
		rc(8'h3C, 32'h0);
		$display("test reset_values done");
		foreach (dec_hit[i]) wr(8'h24 + 8'(i) * 8'h04, 4'hF, 32'hFFFF_FFFF);
		wr(8'h3C, 4'hF, 32'hFFFF_FFFF);
		wr(8'h40, 4'hF, 32'hFFFF_FFFF);
		rc(8'h24, 32'hFFF0_FFF0);
		rc(8'h28, 32'h0000_0FFF);
		rc(8'h2C, 32'h0000_0FFF);
		rc(8'h30, 32'h0);
		rc(8'h3C, 32'h0A00_0000);
		rc(8'h40, 32'h0);
		wr(8'h24, 4'h4, 32'h0055_0000);
		rc(8'h24, 32'hFF50_FFF0);
		$display("test access_kinds done");
		// ----------------------------------------------------------------
		// window decode
		// ----------------------------------------------------------------
		wr(8'h24, 4'hF, 32'h1FF0_1000);
		wr(8'h28, 4'hF, 32'h0000_0001);
		wr(8'h2C, 4'hF, 32'h0000_0001);
		@(posedge clk);
		#1;
		for (int i = 0; i < 6; i++) begin
			mem_req_valid = 1'b1;
			mem_req_addr = dec_addr[i];
			@(posedge clk);
			#1;
			`CHK({fwd_valid, fwd_hit}, {1'b1, dec_hit[i]})
		end
		mem_req_valid = 1'b0;
		mem_req_addr = ~mem_req_addr;
		$display("test window_decode done");
		// ----------------------------------------------------------------
		// master timeout, status and error cycle
		// ----------------------------------------------------------------
		for (int r = 0; r < 3; r++) begin
			wr(8'h3C, 4'h8, {ctl_b[r] | 8'h04, 24'h0});
			glob_en = glob_v[r];
			at_head = 1'b1;
			pci_tick = 1'b1;
			n = 0;
			while (completion_discard !== 1'b1 && n < 40) begin
				@(posedge clk);
				#1;
				n++;
			end
			`CHK(n, exp_n[r])
			at_head = 1'b0;
			@(posedge clk);
			#1;
			`CHK(serr_cycle_req, serr_v[r])
			rc(8'h3C, {ctl_b[r] | 8'h04, 24'h0});
		end
		// a repeat mid-count restarts the timer, so expiry comes four edges later
		wr(8'h3C, 4'h8, 32'h0600_0000);
		at_head = 1'b1;
		n = 0;
		while (completion_discard !== 1'b1 && n < 40) begin
			rep = (n == 3);
			@(posedge clk);
			#1;
			n++;
		end
		rep = 1'b0;
		at_head = 1'b0;
		`CHK(n, SHORT_T + 5)
		wr(8'h3C, 4'h8, 32'h0800_0000);
		rc(8'h3C, 32'h0C00_0000);
		bus_is_66mhz = 1'b1;
		wr(8'h3C, 4'h8, 32'h0C00_0000);
		rc(8'h3C, 32'h8800_0000);
		$display("test timeout_status done");
		tally_and_finish();
	end
endmodule // bpw_regs_test

bind bpw_regs bpw_regs_checker #(.LONG_TIMEOUT(LONG_TIMEOUT), .SHORT_TIMEOUT(SHORT_TIMEOUT))
	u_bpw_regs_checker (.clk(clk), .nrst(nrst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
	.mem_req_valid(mem_req_valid), .mem_req_addr(mem_req_addr), .fwd_valid(fwd_valid),
	.fwd_hit(fwd_hit), .bus_is_66mhz(bus_is_66mhz),
	.global_system_error_enable(global_system_error_enable), .pci_tick(pci_tick),
	.completion_at_head(completion_at_head), .completion_repeated(completion_repeated),
	.completion_discard(completion_discard), .serr_cycle_req(serr_cycle_req));

`default_nettype wire
